// >>> upc_pkg.sv
// shared constants and types of the usb port power state controller
package upc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int UPC_CLK_PERIOD_NS = 100;
    localparam int UPC_DISCH_TIME_US = 200;
    localparam logic [15:0] UPC_DISCH_CYCLES =
        16'(UPC_DISCH_TIME_US * 1000 / UPC_CLK_PERIOD_NS);
    localparam int UPC_IDLE_TIME_US = 2000;
    localparam logic [15:0] UPC_IDLE_CYCLES =
        16'(UPC_IDLE_TIME_US * 1000 / UPC_CLK_PERIOD_NS);
    localparam int UPC_DWELL_TIME_US = 1000;
    localparam logic [15:0] UPC_DWELL_CYCLES =
        16'(UPC_DWELL_TIME_US * 1000 / UPC_CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] UPC_REG_STATE = 8'h00;
    localparam logic [7:0] UPC_REG_INT_STATUS = 8'h01;
    localparam logic [7:0] UPC_REG_INT_MASK = 8'h02;
    localparam logic [7:0] UPC_REG_ILIM = 8'h03;
    localparam logic [7:0] UPC_REG_CONTROLS = 8'h04;
    localparam int UPC_INT_ERROR_BIT = 0;
    localparam int UPC_INT_ATTACH_BIT = 1;
    localparam int UPC_INT_REMOVAL_BIT = 2;
    localparam int UPC_INT_WIDTH = 3;
    localparam logic [2:0] UPC_INT_MASK_RESET = 3'h0;

    // ------------------------------------------------------------
    // mode codes: {emulation_enable, mode_select_high, mode_select_low}
    // ------------------------------------------------------------
    localparam logic [2:0] UPC_MODE_NONE = 3'h0;
    localparam logic [2:0] UPC_MODE_PASSTHRU = 3'h1;
    localparam logic [2:0] UPC_MODE_CDP = 3'h3;
    localparam logic [2:0] UPC_MODE_CYCLE = 3'h4;
    localparam logic [3:0] UPC_PROFILE_LAST = 4'h7;

    typedef enum logic [2:0] {
        UPC_OFF, UPC_SLEEP, UPC_DETECT, UPC_ERROR, UPC_ACTIVE
    } upc_state_type;

    typedef struct packed {
        logic pe;
        logic s0;
        logic [2:0] mode;
        logic src_ok;
        logic attached;
        logic fault;
    } upc_inputs_type;

    typedef struct packed {
        upc_inputs_type in;
        upc_state_type pstate;
        logic powered;
        logic on_step;
        logic [15:0] tmr;
        logic awake;
        logic [15:0] idle;
        logic [UPC_INT_WIDTH-1:0] int_status;
        logic [UPC_INT_WIDTH-1:0] int_mask;
        logic [2:0] ilim;
        logic ilim_fixed;
        logic [3:0] profile;
        logic [15:0] prof_tmr;
        logic [7:0] rd_data;
    } upc_regs_type;

endpackage

// >>> upc_power_state_control.sv
// power state controller for a usb port power switch
//
// What this block does
// - below core supply threshold: Off, state lost, bus ignored, switches open.
// - Sleep keeps logic, follows emulation controls, wakes for bus; switches off.
// - Detect looks for attach when mode nonzero, high-speed off, keeps config, no monitoring.
// - register port fully usable while in Detect.
// - any fault forces Error whatever the controls select.
// - Active closes port switch, runs emulation except in pass-through, limiting and current monitoring.
// - Sleep for enable off, select 0, not pass-through; or enable, select 0, mode 0.
// - Detect when select 1 and enable off, or supply low with mode nonzero.
// - supply good, enable, select 1, mode nonzero, unattached: Detect until attach.
// - supply good, enable, select 0, mode nonzero: Active, port always on.
// - supply good, enable, select 1, mode nonzero, attached: Active, removal on.
// - select 0, unattached, cycle mode: keep stepping through emulation profiles.
// - current limit fixed at power-up; software may only lower it.
// - Detect to Active: attach off, bypass open, discharge, then port on.
// - first read in Sleep wakes and returns zero; idle time resleeps.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module upc_power_state_control
    import upc_pkg::*;
#(
    parameter logic [15:0] IDLE_CYCLES = UPC_IDLE_CYCLES,
    parameter logic [15:0] DWELL_CYCLES = UPC_DWELL_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic core_supply_ok,
    input wire logic source_supply_ok,
    input wire logic port_power_enable,
    input wire logic attach_detect_select,
    input wire logic mode_select_low,
    input wire logic mode_select_high,
    input wire logic emulation_enable,
    input wire logic device_attached,
    input wire logic fault,
    input wire logic [2:0] ilim_strap,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [7:0] rd_data,
    output logic irq,
    output logic port_switch_on,
    output logic bypass_switch_on,
    output logic hs_switch_on,
    output logic discharge_on,
    output logic attach_detect_on,
    output logic removal_detect_on,
    output logic current_monitor_on,
    output logic emulation_on,
    output logic [3:0] emulation_profile,
    output logic [2:0] current_limit,
    output logic [2:0] power_state
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam upc_regs_type REGS_RESET = '{
        in: '0, pstate: UPC_OFF, powered: 1'b0, on_step: 1'b0,
        tmr: '0, awake: 1'b0, idle: '0, int_status: '0,
        int_mask: UPC_INT_MASK_RESET, ilim: '0, ilim_fixed: 1'b0,
        profile: '0, prof_tmr: '0, rd_data: '0
    };

    upc_regs_type st_ff;
    upc_regs_type nxt_st;
    logic all_zero;
    logic pass_mode;
    logic to_sleep;
    logic to_detect;
    logic to_active;
    logic bus_open;
    logic disch_phase;
    logic [UPC_INT_WIDTH-1:0] ev;

    assign all_zero = (st_ff.in.mode == UPC_MODE_NONE);
    assign pass_mode = (st_ff.in.mode == UPC_MODE_PASSTHRU);
    assign to_sleep = (!st_ff.in.pe && !st_ff.in.s0 && !pass_mode)
        || (st_ff.in.pe && !st_ff.in.s0 && all_zero);
    assign to_detect = st_ff.in.s0 && (!st_ff.in.pe
        || (!st_ff.in.src_ok && !all_zero)
        || (!st_ff.in.attached && !all_zero)
        || all_zero);
    assign to_active = st_ff.in.pe && st_ff.in.src_ok && !all_zero
        && (!st_ff.in.s0 || st_ff.in.attached);
    assign disch_phase = (st_ff.pstate == UPC_ACTIVE) && !st_ff.on_step;
    // in Sleep the bus stays shut until a read wakes it; that first read is a dummy, and writes before it are ignored
    assign bus_open = st_ff.powered
        && ((st_ff.pstate != UPC_SLEEP) || st_ff.awake);

    always_comb begin
        nxt_st = st_ff;
        ev = '0;
        nxt_st.rd_data = 8'h00;
        nxt_st.in = '{pe: port_power_enable, s0: attach_detect_select,
            mode: {emulation_enable, mode_select_high, mode_select_low},
            src_ok: source_supply_ok, attached: device_attached,
            fault: fault};
        nxt_st.powered = 1'b1;
        // ------------------------------------------------------------
        // power state, re-evaluated every cycle
        // ------------------------------------------------------------
        if (st_ff.in.fault) begin
            nxt_st.pstate = UPC_ERROR;
        end else if (to_active) begin
            nxt_st.pstate = UPC_ACTIVE;
        end else if (to_detect) begin
            nxt_st.pstate = UPC_DETECT;
        end else if (to_sleep) begin
            nxt_st.pstate = UPC_SLEEP;
        end else if (st_ff.pstate == UPC_OFF || st_ff.pstate == UPC_ERROR) begin
            nxt_st.pstate = UPC_SLEEP;
        end
        // unlisted combinations keep the present state, except that Off and Error go to Sleep
        if (nxt_st.pstate == UPC_ACTIVE && st_ff.pstate != UPC_ACTIVE) begin
            // discharge only when coming from the bypass-fed Detect state
            nxt_st.on_step = (st_ff.pstate != UPC_DETECT);
            nxt_st.tmr = '0;
            if (st_ff.pstate == UPC_DETECT) begin
                ev[UPC_INT_ATTACH_BIT] = 1'b1;
            end
        end else if (disch_phase) begin
            nxt_st.tmr = st_ff.tmr + 16'h0001;
            if (st_ff.tmr == UPC_DISCH_CYCLES - 16'h0001) begin
                nxt_st.on_step = 1'b1;
            end
        end
        if (nxt_st.pstate == UPC_ERROR && st_ff.pstate != UPC_ERROR) begin
            ev[UPC_INT_ERROR_BIT] = 1'b1;
        end
        // raw pin: the flag is set as the registered copy falls
        if (st_ff.pstate == UPC_ACTIVE && st_ff.in.s0 && st_ff.in.attached
            && !device_attached) begin
            ev[UPC_INT_REMOVAL_BIT] = 1'b1;
        end
        // ------------------------------------------------------------
        // emulation profile cycling
        // ------------------------------------------------------------
        if (st_ff.pstate == UPC_ACTIVE && !st_ff.in.s0 && !st_ff.in.attached
            && st_ff.in.mode == UPC_MODE_CYCLE) begin
            nxt_st.prof_tmr = st_ff.prof_tmr + 16'h0001;
            if (st_ff.prof_tmr == DWELL_CYCLES - 16'h0001) begin
                nxt_st.prof_tmr = '0;
                nxt_st.profile = (st_ff.profile == UPC_PROFILE_LAST)
                    ? 4'h0 : st_ff.profile + 4'h1;
            end
        end else begin
            nxt_st.prof_tmr = '0;
        end
        // ------------------------------------------------------------
        // current limit strap, caught once after reset release
        // ------------------------------------------------------------
        if (!st_ff.ilim_fixed) begin
            nxt_st.ilim = ilim_strap;
            nxt_st.ilim_fixed = 1'b1;
        end
        // ------------------------------------------------------------
        // sleep wake and idle return
        // ------------------------------------------------------------
        if (st_ff.pstate != UPC_SLEEP) begin
            nxt_st.awake = 1'b0;
            nxt_st.idle = '0;
        end else if (rd_strobe || wr_strobe) begin
            nxt_st.idle = '0;
            if (rd_strobe) begin
                nxt_st.awake = 1'b1;
            end
        end else if (st_ff.awake) begin
            nxt_st.idle = st_ff.idle + 16'h0001;
            if (st_ff.idle == IDLE_CYCLES - 16'h0001) begin
                nxt_st.awake = 1'b0;
                nxt_st.idle = '0;
            end
        end
        // ------------------------------------------------------------
        // register port
        // ------------------------------------------------------------
        if (rd_strobe && bus_open) begin
            unique case (addr)
                UPC_REG_STATE: begin
                    nxt_st.rd_data = {3'h0, st_ff.on_step, st_ff.awake,
                        3'(st_ff.pstate)};
                end
                UPC_REG_INT_STATUS: begin
                    nxt_st.rd_data = {5'h00, st_ff.int_status};
                end
                UPC_REG_INT_MASK: begin
                    nxt_st.rd_data = {5'h00, st_ff.int_mask};
                end
                UPC_REG_ILIM: begin
                    nxt_st.rd_data = {5'h00, st_ff.ilim};
                end
                UPC_REG_CONTROLS: begin
                    nxt_st.rd_data = {st_ff.profile, 1'b0,
                        st_ff.in.mode};
                end
                default: begin
                    nxt_st.rd_data = 8'h00;
                end
            endcase
        end
        nxt_st.int_status = st_ff.int_status;
        if (wr_strobe && bus_open) begin
            unique case (addr)
                UPC_REG_INT_STATUS: begin
                    nxt_st.int_status = st_ff.int_status
                        & ~wr_data[UPC_INT_WIDTH-1:0];
                end
                UPC_REG_INT_MASK: begin
                    nxt_st.int_mask = wr_data[UPC_INT_WIDTH-1:0];
                end
                UPC_REG_ILIM: begin
                    if (st_ff.ilim_fixed && wr_data[2:0] <= st_ff.ilim) begin
                        nxt_st.ilim = wr_data[2:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // a new event outranks a clear in the same cycle
        nxt_st.int_status = nxt_st.int_status | ev;
        if (!core_supply_ok) begin
            nxt_st = REGS_RESET;
        end
    end

    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            st_ff <= REGS_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs decoded from the registered state
    // ------------------------------------------------------------
    always_comb begin
        port_switch_on = (st_ff.pstate == UPC_ACTIVE) && st_ff.on_step;
        bypass_switch_on = (st_ff.pstate == UPC_DETECT) && !all_zero;
        discharge_on = disch_phase;
        hs_switch_on = port_switch_on && (pass_mode
            || st_ff.in.mode == UPC_MODE_CDP);
        attach_detect_on = (st_ff.pstate == UPC_DETECT) && !all_zero;
        removal_detect_on = (st_ff.pstate == UPC_ACTIVE)
            && st_ff.in.s0;
        current_monitor_on = port_switch_on;
        emulation_on = port_switch_on && !pass_mode;
    end

    assign emulation_profile = st_ff.profile;
    assign current_limit = st_ff.ilim;
    assign power_state = 3'(st_ff.pstate);
    assign rd_data = st_ff.rd_data;
    assign irq = |(st_ff.int_status & st_ff.int_mask);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n_ff);

    off_state_a: assert property (!core_supply_ok |=>
        st_ff.pstate == UPC_OFF && !port_switch_on && !bypass_switch_on)
        else $error("not off after core supply loss");
    fault_error_a: assert property (core_supply_ok && fault
        ##1 core_supply_ok |=> st_ff.pstate == UPC_ERROR)
        else $error("fault did not force error state");
    error_switch_a: assert property (st_ff.pstate == UPC_ERROR |->
        !port_switch_on && !bypass_switch_on && !hs_switch_on)
        else $error("switch closed in error state");
    sleep_switch_a: assert property (st_ff.pstate == UPC_SLEEP |->
        !port_switch_on && !bypass_switch_on && !hs_switch_on)
        else $error("switch closed in sleep");
    detect_port_a: assert property (st_ff.pstate == UPC_DETECT |->
        !port_switch_on && !hs_switch_on && !current_monitor_on)
        else $error("port or monitor on in detect");
    active_cond_a: assert property (st_ff.pstate == UPC_ACTIVE |->
        $past(st_ff.in.pe) && $past(st_ff.in.src_ok) && !$past(all_zero))
        else $error("active without enabling conditions");
    discharge_seq_a: assert property (st_ff.pstate == UPC_DETECT
        && core_supply_ok ##1 st_ff.pstate == UPC_ACTIVE |->
        discharge_on && !port_switch_on && !bypass_switch_on)
        else $error("detect to active skipped discharge");
    port_after_a: assert property ($fell(discharge_on)
        && st_ff.pstate == UPC_ACTIVE |-> port_switch_on)
        else $error("port not closed after discharge");
    dummy_read_a: assert property (rd_strobe && core_supply_ok
        && st_ff.pstate == UPC_SLEEP && !st_ff.awake |=>
        rd_data == 8'h00 && (st_ff.awake || !core_supply_ok
        || st_ff.pstate != UPC_SLEEP))
        else $error("sleep read not a dummy wake");
    ilim_raise_a: assert property (st_ff.ilim_fixed
        && $past(st_ff.ilim_fixed) |-> st_ff.ilim <= $past(st_ff.ilim))
        else $error("current limit was raised");
    irq_error_a: assert property ($rose(st_ff.pstate == UPC_ERROR)
        && st_ff.int_mask[UPC_INT_ERROR_BIT] |-> irq)
        else $error("error entry without interrupt");
    disch_len_a: assert property ($fell(discharge_on)
        && st_ff.pstate == UPC_ACTIVE |->
        $past(st_ff.tmr) == UPC_DISCH_CYCLES - 16'h0001)
        else $error("discharge interval length wrong");
    detect_bypass_a: assert property (st_ff.pstate == UPC_DETECT
        && !all_zero |-> bypass_switch_on && attach_detect_on)
        else $error("bypass or attach detect off in detect");
    hs_gate_a: assert property (hs_switch_on |->
        st_ff.pstate == UPC_ACTIVE && port_switch_on)
        else $error("high-speed switch on outside active");

    wake_read_c: cover property (st_ff.pstate == UPC_SLEEP && !st_ff.awake
        ##1 st_ff.awake);
    detect_active_c: cover property (st_ff.pstate == UPC_DETECT
        ##1 discharge_on);
    disch_done_c: cover property (discharge_on
        && st_ff.tmr == UPC_DISCH_CYCLES - 16'h0001 ##1 port_switch_on);
    error_exit_c: cover property (st_ff.pstate == UPC_ERROR
        ##1 st_ff.pstate == UPC_ACTIVE);
    profile_step_c: cover property ($changed(emulation_profile));

endmodule

// >>> upc_port_partner.sv
// model of the portable device plugged into the port
`timescale 1ns/1ps
module upc_port_partner #(
    parameter int ATTACH_DLY = 4
) (
    input wire logic clock,
    input wire logic plug,
    input wire logic short_circuit,
    input wire logic port_switch_on,
    output logic device_attached = 1'b0,
    output logic fault = 1'b0
);
    int cnt = 0;

    // ------------------------------------------------------------
    // attach comparator and overload
    // ------------------------------------------------------------
    // attach shows only after a settling delay; removal shows at once
    always @(posedge clock) begin
        if (!plug) begin
            cnt <= 0;
            device_attached <= 1'b0;
        end else if (cnt < ATTACH_DLY) begin
            cnt <= cnt + 1;
        end else begin
            device_attached <= 1'b1;
        end
        // a short only trips once powered, then stays until removed
        if (!short_circuit) begin
            fault <= 1'b0;
        end else if (port_switch_on) begin
            fault <= 1'b1;
        end
    end
endmodule

// >>> usb_port_power_state_control_tb.sv
// self-checking testbench of the usb port power state controller
`timescale 1ns/1ps
module usb_port_power_state_control_tb;
    import upc_pkg::*;
    localparam logic [15:0] IDLE = 16'h0014;
    localparam logic [15:0] DWELL = 16'h000A;
    logic clock = 1'b0, resetn = 1'b0, core_ok = 1'b1, src = 1'b0;
    logic pe = 1'b0, s0 = 1'b0, plug = 1'b0, short_c = 1'b0;
    logic wr_strobe = 1'b0, rd_strobe = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [7:0] addr = 8'h00, wr_data = 8'h00, d;
    logic [7:0] rd_data;
    logic [3:0] prof;
    logic [2:0] ilim, pst;
    logic irq, port, byp, hs, dis, att, rem, mon, emu, dev, flt;
    int mismatches = 0, total_checks = 0, cycles = 0;

    upc_port_partner u_partner (.clock(clock), .plug(plug),
        .short_circuit(short_c), .port_switch_on(port),
        .device_attached(dev), .fault(flt));

    upc_power_state_control #(.IDLE_CYCLES(IDLE), .DWELL_CYCLES(DWELL))
    u_dut (.clock(clock), .resetn(resetn), .core_supply_ok(core_ok),
        .source_supply_ok(src), .port_power_enable(pe),
        .attach_detect_select(s0), .mode_select_low(mode[0]),
        .mode_select_high(mode[1]), .emulation_enable(mode[2]),
        .device_attached(dev), .fault(flt), .ilim_strap(3'h5),
        .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .irq(irq),
        .port_switch_on(port), .bypass_switch_on(byp),
        .hs_switch_on(hs), .discharge_on(dis), .attach_detect_on(att),
        .removal_detect_on(rem), .current_monitor_on(mon),
        .emulation_on(emu), .emulation_profile(prof),
        .current_limit(ilim), .power_state(pst));

    initial forever #50 clock = ~clock;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a hang costs one mismatch and ends the run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            mismatches++;
            stop_test();
        end
    end

    task chk(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // pins are registered, then decoded: two edges, one spare
    task pins(input logic p, s, v, input logic [2:0] m);
        @(posedge clock);
        pe <= p;
        s0 <= s;
        src <= v;
        mode <= m;
        tick(3);
    endtask

    task rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1 d = rd_data;
    endtask

    task wr(input logic [7:0] a, v);
        @(posedge clock);
        addr <= a;
        wr_data <= v;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask

    task wait_state(input logic [2:0] s, input int n);
        for (int i = 0; i < n && pst !== s; i++) tick(1);
    endtask

    task sw(input logic p, b, h);
        chk("port", port, p);
        chk("bypass", byp, b);
        chk("hs", hs, h);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_sleep;
        pins(1'b1, 1'b0, 1'b1, UPC_MODE_NONE);
        chk("sleep b", pst, UPC_SLEEP);
        sw(1'b0, 1'b0, 1'b0);
        pins(1'b0, 1'b0, 1'b1, UPC_MODE_CDP);
        chk("sleep a", pst, UPC_SLEEP);
        wr(UPC_REG_INT_MASK, 8'h07);
        rd(UPC_REG_CONTROLS);
        chk("dummy", d, 8'h00);
        rd(UPC_REG_CONTROLS);
        chk("mode", d[2:0], UPC_MODE_CDP);
        rd(UPC_REG_INT_MASK);
        chk("asleep wr", d, 8'h00);
        rd(UPC_REG_STATE);
        chk("awake", d[3:0], 4'h9);
        tick(IDLE + 5);
        rd(UPC_REG_STATE);
        chk("resleep", d, 8'h00);
        $display("test sleep done");
    endtask

    task t_detect;
        int n;
        logic early;
        pins(1'b0, 1'b1, 1'b1, UPC_MODE_CDP);
        chk("det a", pst, UPC_DETECT);
        sw(1'b0, 1'b1, 1'b0);
        chk("monitor", mon, 1'b0);
        wr(UPC_REG_INT_MASK, 8'h07);
        rd(UPC_REG_INT_MASK);
        chk("mask", d, 8'h07);
        pins(1'b1, 1'b1, 1'b0, UPC_MODE_CDP);
        chk("det b", pst, UPC_DETECT);
        pins(1'b1, 1'b1, 1'b1, UPC_MODE_CDP);
        chk("det c", pst, UPC_DETECT);
        chk("attach on", att, 1'b1);
        @(posedge clock) plug <= 1'b1;
        wait_state(UPC_ACTIVE, 40);
        chk("auto act", pst, UPC_ACTIVE);
        chk("attach off", att, 1'b0);
        chk("dis", dis, 1'b1);
        sw(1'b0, 1'b0, 1'b0);
        n = 0;
        early = 1'b0;
        while (dis === 1'b1 && n < 3000) begin
            early |= port;
            n++;
            tick(1);
        end
        chk("early", early, 1'b0);
        chk("dis len", n, UPC_DISCH_CYCLES);
        sw(1'b1, 1'b0, 1'b1);
        chk("removal", rem, 1'b1);
        chk("monitor", mon, 1'b1);
        chk("irq", irq, 1'b1);
        rd(UPC_REG_INT_STATUS);
        chk("st att", d, 8'h02);
        wr(UPC_REG_INT_STATUS, 8'h02);
        tick(1);
        chk("irq clr", irq, 1'b0);
        @(posedge clock) plug <= 1'b0;
        tick(4);
        chk("unplug", pst, UPC_DETECT);
        rd(UPC_REG_INT_STATUS);
        chk("st rem", d, 8'h04);
        wr(UPC_REG_INT_STATUS, 8'h04);
        $display("test detect done");
    endtask

    task t_pass;
        pins(1'b1, 1'b0, 1'b1, UPC_MODE_NONE);
        pins(1'b1, 1'b0, 1'b1, UPC_MODE_PASSTHRU);
        chk("act s0", pst, UPC_ACTIVE);
        sw(1'b1, 1'b0, 1'b1);
        chk("no dis", dis, 1'b0);
        chk("no att", att, 1'b0);
        chk("no rem", rem, 1'b0);
        chk("no emu", emu, 1'b0);
        pins(1'b1, 1'b0, 1'b1, UPC_MODE_NONE);
        pins(1'b0, 1'b0, 1'b1, UPC_MODE_NONE);
        chk("leave", pst, UPC_SLEEP);
        sw(1'b0, 1'b0, 1'b0);
        $display("test pass done");
    endtask

    task t_fault;
        pins(1'b1, 1'b0, 1'b1, UPC_MODE_CDP);
        chk("act", port, 1'b1);
        @(posedge clock) short_c <= 1'b1;
        wait_state(UPC_ERROR, 10);
        chk("err", pst, UPC_ERROR);
        sw(1'b0, 1'b0, 1'b0);
        chk("irq", irq, 1'b1);
        rd(UPC_REG_INT_STATUS);
        chk("st err", d, 8'h01);
        wr(UPC_REG_INT_STATUS, 8'h01);
        @(posedge clock) short_c <= 1'b0;
        wait_state(UPC_ACTIVE, 10);
        chk("recover", pst, UPC_ACTIVE);
        chk("port", port, 1'b1);
        rd(UPC_REG_INT_STATUS);
        chk("st clr", d, 8'h00);
        $display("test fault done");
    endtask

    task t_cycle;
        logic [3:0] p;
        int n;
        pins(1'b1, 1'b0, 1'b1, UPC_MODE_CYCLE);
        chk("emu", emu, 1'b1);
        p = prof;
        for (n = 0; prof === p && n < 40; n++) tick(1);
        for (int k = 0; k < 9; k++) begin
            p = prof;
            for (n = 0; prof === p && n < 40; n++) tick(1);
            chk("dwell", n, DWELL);
            chk("profile", prof,
                (p == UPC_PROFILE_LAST) ? 4'h0 : p + 4'h1);
        end
        $display("test cycle done");
    endtask

    task t_regs;
        rd(UPC_REG_ILIM);
        chk("ilim rst", d, 8'h05);
        wr(UPC_REG_ILIM, 8'h03);
        rd(UPC_REG_ILIM);
        chk("ilim low", d, 8'h03);
        wr(UPC_REG_ILIM, 8'h06);
        rd(UPC_REG_ILIM);
        chk("ilim up", d, 8'h03);
        chk("limit", ilim, 3'h3);
        rd(UPC_REG_STATE);
        chk("state rd", d[2:0], UPC_ACTIVE);
        wr(8'h7F, 8'hFF);
        rd(8'h7F);
        chk("unmapped", d, 8'h00);
        $display("test regs done");
    endtask

    task t_off;
        @(posedge clock) core_ok <= 1'b0;
        tick(2);
        chk("off", pst, UPC_OFF);
        sw(1'b0, 1'b0, 1'b0);
        rd(UPC_REG_INT_MASK);
        chk("off bus", d, 8'h00);
        @(posedge clock) core_ok <= 1'b1;
        tick(4);
        chk("back", pst, UPC_ACTIVE);
        rd(UPC_REG_INT_MASK);
        chk("lost", d, 8'h00);
        $display("test off done");
    endtask

    initial begin
        repeat (2) @(posedge clock);
        #1;
        chk("reset", pst, UPC_OFF);
        sw(1'b0, 1'b0, 1'b0);
        @(posedge clock) resetn <= 1'b1;
        tick(6);
        chk("first", pst, UPC_SLEEP);
        t_sleep();
        t_detect();
        t_pass();
        t_fault();
        t_cycle();
        t_regs();
        t_off();
        stop_test();
    end
endmodule
